// ### rtl/srl_defines.svh
`ifndef SRL_DEFINES_SVH
`define SRL_DEFINES_SVH

// byte codes on the serial link, and how many times an error code is sent
`define SRL_SYNC_BYTE       8'h5a
`define SRL_BAUD_9600       8'h28
`define SRL_CMD_RAM_LOAD    8'h60
`define SRL_START_MARK      8'h3a
`define SRL_ERR_FRAMING     8'ha1
`define SRL_ERR_OVERRUN     8'ha3
`define SRL_ERR_BAUD        8'h62
`define SRL_ERR_CMD         8'h63
`define SRL_ERR_REPEAT      2'h3

// blank-part window and erased value
`define SRL_BLANK_BASE      16'hffe0
`define SRL_BLANK_LAST_IDX  8'h1f
`define SRL_ERASED          8'hff

// record types and record field positions
`define SRL_REC_DATA        8'h00
`define SRL_REC_END         8'h01
`define SRL_FLD_LEN         3'h0
`define SRL_FLD_ADDR_HI     3'h1
`define SRL_FLD_ADDR_LO     3'h2
`define SRL_FLD_TYPE        3'h3
`define SRL_FLD_DATA        3'h4
`define SRL_FLD_SUM         3'h5

// receive queue shape: {overrun, framing, data}
`define SRL_FIFO_WIDTH      10
`define SRL_FIFO_DEPTH      16
`define SRL_FIFO_OERR_BIT   9
`define SRL_FIFO_FERR_BIT   8

`endif

// ### rtl/srl_fifo.sv
`timescale 1ns/1ps
`include "srl_defines.svh"
module srl_fifo
	import srl_pkg::*;
#(
	parameter int WIDTH = `SRL_FIFO_WIDTH,
	parameter int DEPTH = `SRL_FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             in_ready,
	srl_stream_if.src             out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	srl_fifo_state_t  s_r;
	srl_fifo_state_t  s_nxt;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	// pointers carry a wrap bit so full and empty differ honestly
	assign empty    = (s_r.wp == s_r.rp);
	assign full     = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
	assign in_ready = !full;
	assign out.valid = !empty;
	assign out.data  = mem[s_r.rp[AW-1:0]];
	assign push     = ce && in_valid && !full;
	assign pop      = ce && out.ready && !empty;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
			s_nxt.wp = s_r.wp + 5'h01;
		if (pop)
			s_nxt.rp = s_r.rp + 5'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// storage has no reset; only pointed-to words are ever read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[s_r.wp[AW-1:0]] <= in_data;
	end
endmodule : srl_fifo

// ### rtl/srl_loader.sv
`timescale 1ns/1ps
`include "srl_defines.svh"
module srl_loader
	import srl_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        CE,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_FERR,
	input  wire logic        RX_OERR,
	output      logic        RX_READY,
	output      logic        TX_VALID,
	output      logic [7:0]  TX_DATA,
	input  wire logic        TX_READY,
	output      logic        AUTOBAUD_EN,
	output      logic [7:0]  BAUD_CODE,
	input  wire logic        BAUD_CODE_OK,
	output      logic        BAUD_APPLY,
	input  wire logic        SECURE_EN,
	output      logic        MEM_RD_EN,
	output      logic [15:0] MEM_RD_ADDR,
	input  wire logic [7:0]  MEM_RD_DATA,
	output      logic        RAM_WE,
	output      logic [15:0] RAM_ADDR,
	output      logic [7:0]  RAM_WDATA,
	output      logic        JUMP_VALID,
	output      logic [15:0] JUMP_ADDR,
	output      logic        HALTED
);
	srl_stream_if   rxq ();
	srl_ldr_state_t s_r;
	srl_ldr_state_t s_nxt;
	logic           want;
	logic           take;
	logic [7:0]     rx_byte;
	logic           rx_ferr;
	logic           rx_oerr;
	logic           rx_err;
	logic           tx_done;

	// receive queue decouples the UART from memory-read stalls
	srl_fifo #(
		.WIDTH (`SRL_FIFO_WIDTH),
		.DEPTH (`SRL_FIFO_DEPTH)
	) u_rxq (
		.clk      (CLK),
		.rstn     (RSTN),
		.ce       (CE),
		.in_valid (RX_VALID),
		.in_data  ({RX_OERR, RX_FERR, RX_DATA}),
		.in_ready (RX_READY),
		.out      (rxq.src)
	);

	assign rx_byte = rxq.data[7:0];
	assign rx_ferr = rxq.data[`SRL_FIFO_FERR_BIT];
	assign rx_oerr = rxq.data[`SRL_FIFO_OERR_BIT];
	assign rx_err  = rx_ferr || rx_oerr;

	// a byte is drained only in receiving states with no read or send in flight
	always_comb
	begin
		case (s_r.st)
			SRL_S_SYNC, SRL_S_BAUD, SRL_S_CMD, SRL_S_ADDR,
			SRL_S_PW_STR, SRL_S_HEX, SRL_S_REC:
				want = !s_r.rd_r && !s_r.rd_wait && !s_r.tx_valid;
			default:
				want = 1'b0;
		endcase
	end

	assign rxq.ready = want;
	assign take      = CE && want && rxq.valid;
	assign tx_done   = CE && s_r.tx_valid && TX_READY;

	// next-state logic for the whole boot sequence
	always_comb
	begin
		s_nxt            = s_r;
		s_nxt.baud_apply = 1'b0;
		s_nxt.ram_we     = 1'b0;
		// memory read: enable for one cycle, data valid the cycle after
		s_nxt.rd_wait    = s_r.rd_r;
		s_nxt.rd_r       = 1'b0;
		case (s_r.st)
			SRL_S_SYNC:
				if (take && !rx_err && rx_byte == `SRL_SYNC_BYTE)
				begin
					s_nxt.tx_valid = 1'b1;
					s_nxt.tx_data  = rx_byte;
					s_nxt.ret      = SRL_S_BAUD;
					s_nxt.st       = SRL_S_TX;
				end
			SRL_S_BAUD:
				if (take)
				begin
					s_nxt.baud     = rx_byte;
					s_nxt.tx_data  = rx_ferr ? `SRL_ERR_FRAMING : `SRL_ERR_OVERRUN;
					s_nxt.tx_valid = rx_err;
					s_nxt.st       = rx_err ? SRL_S_ERR : SRL_S_BAUD_CHK;
				end
			// rate generator judges the candidate code against its own clock
			SRL_S_BAUD_CHK:
			begin
				s_nxt.tx_valid = 1'b1;
				s_nxt.tx_data  = BAUD_CODE_OK ? s_r.baud : `SRL_ERR_BAUD;
				s_nxt.ret      = SRL_S_CMD;
				s_nxt.st       = BAUD_CODE_OK ? SRL_S_TX : SRL_S_ERR;
			end
			SRL_S_CMD:
				if (take)
				begin
					s_nxt.tx_valid = 1'b1;
					s_nxt.ret      = SRL_S_ADDR;
					s_nxt.st       = SRL_S_ERR;
					if (rx_err)
						s_nxt.tx_data = rx_ferr ? `SRL_ERR_FRAMING : `SRL_ERR_OVERRUN;
					else if (rx_byte == `SRL_CMD_RAM_LOAD)
					begin
						s_nxt.tx_data = rx_byte;
						s_nxt.st      = SRL_S_TX;
					end
					else
						s_nxt.tx_data = `SRL_ERR_CMD;
				end
			// four silent address bytes, high byte first
			SRL_S_ADDR:
				if (take)
				begin
					if (rx_err)
						s_nxt.st = SRL_S_HALT;
					else
					begin
						s_nxt.pw_addr = {s_r.pw_addr[23:0], rx_byte};
						s_nxt.acnt    = s_r.acnt + 2'h1;
						if (s_r.acnt == 2'h3)
						begin
							s_nxt.st      = SRL_S_BLANK;
							s_nxt.blank   = 1'b1;
							s_nxt.idx     = 8'h00;
							s_nxt.rd_r    = 1'b1;
							s_nxt.rd_addr = `SRL_BLANK_BASE;
						end
					end
				end
			// scan the top window byte by byte for the erased value
			SRL_S_BLANK:
				if (s_r.rd_wait)
				begin
					if (s_r.idx == `SRL_BLANK_LAST_IDX)
					begin
						if (s_r.blank && MEM_RD_DATA == `SRL_ERASED)
							s_nxt.st = SRL_S_HEX;
						else if (SECURE_EN)
							s_nxt.st = SRL_S_HALT;
						else
						begin
							s_nxt.st      = SRL_S_PW_CNT;
							s_nxt.rd_r    = 1'b1;
							s_nxt.rd_addr = s_r.pw_addr[31:16];
						end
					end
					else
					begin
						if (MEM_RD_DATA != `SRL_ERASED)
							s_nxt.blank = 1'b0;
						s_nxt.idx     = s_r.idx + 8'h01;
						s_nxt.rd_r    = 1'b1;
						s_nxt.rd_addr = `SRL_BLANK_BASE + {8'h00, s_r.idx} + 16'h0001;
					end
				end
			// a zero count can only come from a bad count address
			SRL_S_PW_CNT:
				if (s_r.rd_wait)
				begin
					s_nxt.pw_n = MEM_RD_DATA;
					s_nxt.idx  = 8'h00;
					s_nxt.st   = (MEM_RD_DATA == 8'h00) ? SRL_S_HALT : SRL_S_PW_STR;
				end
			SRL_S_PW_STR:
				if (take)
				begin
					if (rx_err)
						s_nxt.st = SRL_S_HALT;
					else
					begin
						s_nxt.rbuf    = rx_byte;
						s_nxt.rd_r    = 1'b1;
						s_nxt.rd_addr = s_r.pw_addr[15:0] + {8'h00, s_r.idx};
						s_nxt.st      = SRL_S_PW_CMP;
					end
				end
			SRL_S_PW_CMP:
				if (s_r.rd_wait)
				begin
					s_nxt.idx = s_r.idx + 8'h01;
					if (MEM_RD_DATA != s_r.rbuf)
						s_nxt.st = SRL_S_HALT;
					else if (s_r.idx + 8'h01 == s_r.pw_n)
						s_nxt.st = SRL_S_HEX;
					else
						s_nxt.st = SRL_S_PW_STR;
				end
			// hunt for the start mark; other clean bytes are dropped, a receive error halts
			SRL_S_HEX:
				if (take)
				begin
					if (rx_err)
						s_nxt.st = SRL_S_HALT;
					else if (rx_byte == `SRL_START_MARK)
					begin
						s_nxt.st   = SRL_S_REC;
						s_nxt.fld  = `SRL_FLD_LEN;
						s_nxt.rsum = 8'h00;
						s_nxt.dcnt = 8'h00;
					end
				end
			SRL_S_REC:
				if (take)
				begin
					s_nxt.rsum = srl_rec_sum(s_r.rsum, rx_byte);
					if (rx_err)
						s_nxt.st = SRL_S_HALT;
					else
						case (s_r.fld)
							`SRL_FLD_LEN:
							begin
								s_nxt.rlen = rx_byte;
								s_nxt.fld  = `SRL_FLD_ADDR_HI;
							end
							`SRL_FLD_ADDR_HI:
							begin
								s_nxt.raddr[15:8] = rx_byte;
								s_nxt.fld         = `SRL_FLD_ADDR_LO;
							end
							`SRL_FLD_ADDR_LO:
							begin
								s_nxt.raddr[7:0] = rx_byte;
								s_nxt.fld        = `SRL_FLD_TYPE;
							end
							`SRL_FLD_TYPE:
							begin
								s_nxt.rtype = rx_byte;
								s_nxt.fld   = (s_r.rlen == 8'h00) ? `SRL_FLD_SUM : `SRL_FLD_DATA;
								if (rx_byte == `SRL_REC_DATA && !s_r.first)
								begin
									s_nxt.first = 1'b1;
									s_nxt.jaddr = s_r.raddr;
								end
								// unknown type, or an end record carrying data, is malformed
								if (rx_byte != `SRL_REC_DATA &&
									!(rx_byte == `SRL_REC_END && s_r.rlen == 8'h00))
									s_nxt.st = SRL_S_HALT;
							end
							`SRL_FLD_DATA:
							begin
								s_nxt.ram_we    = 1'b1;
								s_nxt.ram_addr  = s_r.raddr + {8'h00, s_r.dcnt};
								s_nxt.ram_wdata = rx_byte;
								s_nxt.run_sum   = srl_load_sum(s_r.run_sum, rx_byte);
								s_nxt.dcnt      = s_r.dcnt + 8'h01;
								if (s_r.dcnt + 8'h01 == s_r.rlen)
									s_nxt.fld = `SRL_FLD_SUM;
							end
							default:
								if (srl_rec_sum(s_r.rsum, rx_byte) != 8'h00)
									s_nxt.st = SRL_S_HALT;
								else if (s_r.rtype == `SRL_REC_END)
								begin
									s_nxt.load_checksum = s_r.run_sum;
									s_nxt.st            = SRL_S_SUM_HI;
								end
								else
									s_nxt.st = SRL_S_HEX;
						endcase
				end
			SRL_S_SUM_HI:
			begin
				s_nxt.tx_valid = 1'b1;
				s_nxt.tx_data  = s_r.load_checksum[15:8];
				s_nxt.ret      = SRL_S_SUM_LO;
				s_nxt.st       = SRL_S_TX;
			end
			SRL_S_SUM_LO:
			begin
				s_nxt.tx_valid = 1'b1;
				s_nxt.tx_data  = s_r.load_checksum[7:0];
				s_nxt.ret      = SRL_S_JUMP;
				s_nxt.st       = SRL_S_TX;
			end
			SRL_S_JUMP:
				s_nxt.jump = 1'b1;
			// one byte out, then resume; the rate switches after the rate echo
			SRL_S_TX:
				if (tx_done)
				begin
					s_nxt.tx_valid = 1'b0;
					s_nxt.st       = s_r.ret;
					if (s_r.ret == SRL_S_CMD)
						s_nxt.baud_apply = 1'b1;
				end
			// error code goes out three times, then the loader halts
			SRL_S_ERR:
				if (tx_done)
				begin
					s_nxt.err_cnt = s_r.err_cnt + 2'h1;
					if (s_r.err_cnt + 2'h1 == `SRL_ERR_REPEAT)
					begin
						s_nxt.tx_valid = 1'b0;
						s_nxt.st       = SRL_S_HALT;
					end
				end
			SRL_S_HALT:
				s_nxt.halted = 1'b1;
			default:
				s_nxt.st = SRL_S_HALT;
		endcase
	end

	// clock enable freezes every bit of state
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
			s_r <= '0;
		else if (CE)
			s_r <= s_nxt;
	end

	// outputs straight from state flip-flops, but the autobaud enable is decoded from the state
	assign TX_VALID    = s_r.tx_valid;
	assign TX_DATA     = s_r.tx_data;
	assign AUTOBAUD_EN = (s_r.st == SRL_S_SYNC);
	assign BAUD_CODE   = s_r.baud;
	assign BAUD_APPLY  = s_r.baud_apply;
	assign MEM_RD_EN   = s_r.rd_r;
	assign MEM_RD_ADDR = s_r.rd_addr;
	assign RAM_WE      = s_r.ram_we;
	assign RAM_ADDR    = s_r.ram_addr;
	assign RAM_WDATA   = s_r.ram_wdata;
	assign JUMP_VALID  = s_r.jump;
	assign JUMP_ADDR   = s_r.jaddr;
	assign HALTED      = s_r.halted;
endmodule : srl_loader

// ### rtl/srl_pkg.sv
package srl_pkg;

	typedef enum logic [4:0] {
		SRL_S_SYNC     = 5'h00,
		SRL_S_BAUD     = 5'h01,
		SRL_S_BAUD_CHK = 5'h02,
		SRL_S_CMD      = 5'h03,
		SRL_S_ADDR     = 5'h04,
		SRL_S_BLANK    = 5'h05,
		SRL_S_PW_CNT   = 5'h06,
		SRL_S_PW_STR   = 5'h07,
		SRL_S_PW_CMP   = 5'h08,
		SRL_S_HEX      = 5'h09,
		SRL_S_REC      = 5'h0a,
		SRL_S_SUM_HI   = 5'h0b,
		SRL_S_SUM_LO   = 5'h0c,
		SRL_S_JUMP     = 5'h0d,
		SRL_S_TX       = 5'h0e,
		SRL_S_ERR      = 5'h0f,
		SRL_S_HALT     = 5'h10
	} srl_state_t;

	// whole loader state; all-zero is the reset value
	typedef struct packed {
		srl_state_t  st;
		srl_state_t  ret;
		logic [7:0]  rbuf;
		logic [1:0]  acnt;
		logic [31:0] pw_addr;
		logic [7:0]  idx;
		logic [7:0]  pw_n;
		logic        blank;
		logic        rd_r;
		logic        rd_wait;
		logic [15:0] rd_addr;
		logic [2:0]  fld;
		logic [7:0]  rlen;
		logic [15:0] raddr;
		logic [7:0]  rtype;
		logic [7:0]  dcnt;
		logic [7:0]  rsum;
		logic        first;
		logic [15:0] jaddr;
		logic [15:0] run_sum;
		logic [15:0] load_checksum;
		logic [1:0]  err_cnt;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic [7:0]  baud;
		logic        baud_apply;
		logic        ram_we;
		logic [15:0] ram_addr;
		logic [7:0]  ram_wdata;
		logic        jump;
		logic        halted;
	} srl_ldr_state_t;

	typedef struct packed {
		logic [4:0] wp;
		logic [4:0] rp;
	} srl_fifo_state_t;

	// per-record checksum step: all bytes of a good record add to zero
	function automatic logic [7:0] srl_rec_sum(input logic [7:0] acc, input logic [7:0] b);
		srl_rec_sum = acc + b;
	endfunction : srl_rec_sum

	// load checksum step over every loaded data byte
	function automatic logic [15:0] srl_load_sum(input logic [15:0] acc, input logic [7:0] b);
		srl_load_sum = acc + {8'h00, b};
	endfunction : srl_load_sum

endpackage : srl_pkg

// ### rtl/srl_stream_if.sv
`timescale 1ns/1ps
interface srl_stream_if;
	logic       valid;
	logic       ready;
	logic [9:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : srl_stream_if

// ### verification/srl_host_model.sv
`timescale 1ns/1ps
module srl_host_model
(
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_data,
	output      logic        tx_ready,
	input  wire logic        rd_en,
	input  wire logic [15:0] rd_addr,
	output      logic [7:0]  rd_data
);
	logic [7:0] mem [0:65535];
	logic [7:0] rx_log [$];
	logic [7:0] rd_q;
	logic       rd_live;
	logic       tick;
	initial
	begin
		foreach (mem[i]) mem[i] = 8'hff;
		rd_q = 8'h00;
		rd_live = 1'b0;
		tick = 1'b0;
	end
	// a slow host takes a byte only every other cycle
	assign tx_ready = !slow || tick;
	// outside the one valid cycle show the inverse, so a stale value never matches
	assign rd_data = rd_live ? rd_q : ~rd_q;
	always @(posedge clk)
	begin
		tick <= !tick;
		rd_live <= rd_en;
		if (rd_en === 1'b1)
			rd_q <= mem[rd_addr];
		if (tx_valid === 1'b1 && tx_ready)
			rx_log.push_back(tx_data);
	end
endmodule : srl_host_model

// ### verification/srl_loader_checker.sv
`timescale 1ns/1ps
module srl_loader_checker
(
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        CE,
	input wire logic        TX_VALID,
	input wire logic [7:0]  TX_DATA,
	input wire logic        TX_READY,
	input wire logic        AUTOBAUD_EN,
	input wire logic        BAUD_APPLY,
	input wire logic        MEM_RD_EN,
	input wire logic        RAM_WE,
	input wire logic [15:0] RAM_ADDR,
	input wire logic        JUMP_VALID,
	input wire logic [15:0] JUMP_ADDR,
	input wire logic        HALTED
);
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	sequence s_tx_wait;
		TX_VALID && !(TX_READY && CE);
	endsequence
	sequence s_two_writes;
		RAM_WE ##1 RAM_WE;
	endsequence
	property p_tx_hold;
		s_tx_wait |=> TX_VALID && $stable(TX_DATA);
	endproperty
	property p_sync_echo;
		$rose(TX_VALID) && $past(AUTOBAUD_EN) |-> TX_DATA == 8'h5a;
	endproperty
	property p_apply;
		BAUD_APPLY |-> $past(TX_VALID && TX_READY && CE) ##1 !BAUD_APPLY;
	endproperty
	property p_halt_sticky;
		HALTED |=> HALTED;
	endproperty
	property p_halt_quiet;
		HALTED && !TX_VALID |=> !TX_VALID;
	endproperty
	property p_read_gap;
		MEM_RD_EN |=> !MEM_RD_EN;
	endproperty
	property p_we_seq;
		s_two_writes |-> RAM_ADDR == $past(RAM_ADDR) + 16'h0001;
	endproperty
	property p_jump;
		JUMP_VALID |=> JUMP_VALID && $stable(JUMP_ADDR) && !TX_VALID;
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost");
	a_sync_echo: assert property (p_sync_echo) else $error("bad sync echo");
	a_apply: assert property (p_apply) else $error("rate switch misplaced");
	a_halt_sticky: assert property (p_halt_sticky) else $error("halt left");
	a_halt_quiet: assert property (p_halt_quiet) else $error("tx after halt");
	a_read_gap: assert property (p_read_gap) else $error("read too soon");
	a_we_seq: assert property (p_we_seq) else $error("ram address skipped");
	a_jump: assert property (p_jump) else $error("jump not held");
endmodule : srl_loader_checker

bind srl_loader srl_loader_checker i_chk (.CLK(CLK), .RSTN(RSTN), .CE(CE),
	.TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .AUTOBAUD_EN(AUTOBAUD_EN),
	.BAUD_APPLY(BAUD_APPLY), .MEM_RD_EN(MEM_RD_EN), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR),
	.JUMP_VALID(JUMP_VALID), .JUMP_ADDR(JUMP_ADDR), .HALTED(HALTED));

// ### verification/test_serial_ram_loader.sv
`timescale 1ns/1ps
module test_serial_ram_loader;
	logic        clk, rstn, ce, rx_valid, rx_ferr, rx_oerr, rx_ready, tx_valid, tx_ready;
	logic        autobaud_en, baud_ok, baud_apply, secure_en, rd_en, ram_we, jump_valid;
	logic        halted, slow;
	logic [7:0]  rx_data, tx_data, baud_code, rd_data, ram_wdata;
	logic [15:0] rd_addr, ram_addr, jump_addr;
	logic [7:0]  ram [0:65535];
	int          err_total, compares;

	srl_loader i_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_FERR(rx_ferr), .RX_OERR(rx_oerr), .RX_READY(rx_ready), .TX_VALID(tx_valid),
		.TX_DATA(tx_data), .TX_READY(tx_ready), .AUTOBAUD_EN(autobaud_en),
		.BAUD_CODE(baud_code), .BAUD_CODE_OK(baud_ok), .BAUD_APPLY(baud_apply),
		.SECURE_EN(secure_en), .MEM_RD_EN(rd_en), .MEM_RD_ADDR(rd_addr), .MEM_RD_DATA(rd_data),
		.RAM_WE(ram_we), .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .JUMP_VALID(jump_valid),
		.JUMP_ADDR(jump_addr), .HALTED(halted));
	srl_host_model i_host (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// image of what the device loaded
	always @(posedge clk)
		if (ram_we === 1'b1)
			ram[ram_addr] <= ram_wdata;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize();
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic do_reset();
		@(posedge clk);
		rstn <= 1'b0;
		rx_valid <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		i_host.rx_log.delete();
	endtask : do_reset

	// byte held until an edge where the queue has room; valid is left up for back to back
	task automatic send(input logic [7:0] b, input logic fe = 1'b0, input logic oe = 1'b0);
		int n;
		n = 0;
		rx_valid <= 1'b1;
		rx_data <= b;
		rx_ferr <= fe;
		rx_oerr <= oe;
		do
			@(posedge clk);
		while (rx_ready !== 1'b1 && n++ < 400);
		if (rx_ready !== 1'b1)
			check("rx accept", 16'h0000, 16'h0001);
	endtask : send

	task automatic send_all(input logic [7:0] q[$]);
		foreach (q[i]) send(q[i]);
	endtask : send_all

	task automatic gap(input int n);
		rx_valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : gap

	task automatic expect_tx(input logic [7:0] b);
		logic [15:0] seen;
		seen = 16'h0100;
		if (i_host.rx_log.size() > 0)
			seen = {8'h00, i_host.rx_log.pop_front()};
		check("tx byte", seen, {8'h00, b});
	endtask : expect_tx

	task automatic tail(input logic h);
		check("halted", {15'h0000, halted}, {15'h0000, h});
		check("tx count", 16'(i_host.rx_log.size()), 16'h0000);
	endtask : tail

	task automatic front();
		do_reset();
		send(8'h5a);
		send(8'h28);
		send(8'h60);
		send_all('{8'h10, 8'h00, 8'h11, 8'h00});
	endtask : front

	task automatic echoes();
		expect_tx(8'h5a);
		expect_tx(8'h28);
		expect_tx(8'h60);
	endtask : echoes

	task automatic t_sync();
		do_reset();
		send(8'h11);
		send(8'h5a, 1'b1);
		gap(30);
		tail(1'b0);
		send(8'h5a);
		gap(30);
		expect_tx(8'h5a);
		check("autobaud", {15'h0000, autobaud_en}, 16'h0000);
	endtask : t_sync

	task automatic t_errors();
		logic [7:0] code [4] = '{8'ha1, 8'ha3, 8'h62, 8'h63};
		for (int i = 0; i < 4; i++)
		begin
			do_reset();
			baud_ok <= (i != 2);
			send(8'h5a);
			send(8'h28, i == 0, i == 1);
			if (i == 3)
				send(8'h30);
			gap(100);
			baud_ok <= 1'b1;
			expect_tx(8'h5a);
			if (i == 3)
				expect_tx(8'h28);
			repeat (3) expect_tx(code[i]);
			tail(1'b1);
			check("rate code", {8'h00, baud_code}, 16'h0028);
		end
	endtask : t_errors

	// blank part, host stalling the return bytes
	task automatic t_load();
		slow <= 1'b1;
		front();
		send(8'h00);
		send_all('{8'h3a, 8'h02, 8'h80, 8'h00, 8'h00, 8'h55, 8'haa, 8'h7f});
		send_all('{8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
		gap(300);
		slow <= 1'b0;
		echoes();
		expect_tx(8'h00);
		expect_tx(8'hff);
		check("jump valid", {15'h0000, jump_valid}, 16'h0001);
		check("jump addr", jump_addr, 16'h8000);
		check("ram lo", {ram[16'h8000], ram[16'h8001]}, 16'h55aa);
		tail(1'b0);
	endtask : t_load

	// protected part: good string, mismatch, security on, receive error in the string,
	// and a count location holding zero, which only a wrong address can give
	task automatic t_password();
		i_host.mem[16'hffe0] = 8'h00;
		i_host.mem[16'h1100] = 8'h12;
		i_host.mem[16'h1101] = 8'h34;
		for (int k = 0; k < 5; k++)
		begin
			i_host.mem[16'h1000] = (k == 4) ? 8'h00 : 8'h02;
			secure_en <= (k == 2);
			front();
			send(8'h12);
			send((k == 1) ? 8'h35 : 8'h34, k == 3);
			send_all('{8'h3a, 8'h01, 8'h90, 8'h00, 8'h00, 8'h77, 8'hf8});
			send_all('{8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
			gap(300);
			echoes();
			if (k == 0)
			begin
				expect_tx(8'h00);
				expect_tx(8'h77);
				check("jump", jump_addr, 16'h9000);
			end
			tail(k != 0);
		end
		i_host.mem[16'hffe0] = 8'hff;
		secure_en <= 1'b0;
	endtask : t_password

	// bad record sum, unknown record type, receive error inside a record: silent halts
	task automatic t_rec_err();
		for (int j = 0; j < 3; j++)
		begin
			front();
			send_all('{8'h3a, 8'h01, 8'h80, 8'h00});
			send((j == 1) ? 8'h02 : 8'h00);
			send(8'h55, j == 2);
			send(8'h00);
			send_all('{8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
			gap(300);
			echoes();
			tail(1'b1);
		end
	endtask : t_rec_err

	initial
	begin
		rstn = 1'b0;
		ce = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_ferr = 1'b0;
		rx_oerr = 1'b0;
		baud_ok = 1'b1;
		secure_en = 1'b0;
		slow = 1'b0;
		err_total = 0;
		compares = 0;
		t_sync();
		t_errors();
		t_load();
		t_password();
		t_rec_err();
		summarize();
	end

	// the run needs about 3600 cycles; this allows 50000
	initial
	begin
		#200000;
		err_total++;
		summarize();
	end
endmodule : test_serial_ram_loader
